/* File: chain_intr_defs.svh */
`ifndef CHAIN_INTR_DEFS_SVH
`define CHAIN_INTR_DEFS_SVH

// Board clock
`define CLK_PERIOD_NS 8

// Least hold time of an input level, kept by the driving equipment
`define MIN_HOLD_NS   1500
`define MIN_HOLD_CYC  ((`MIN_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Line counts and field widths
`define N_ETI_DEFAULT 12
`define N_DI_DEFAULT  8
`define N_RTC_DEFAULT 8
`define N_PIG_DEFAULT 4
`define N_OUT_DEFAULT 4
`define SEL_W_DEFAULT 6
`define TOD_W_DEFAULT 32

// Route select value that connects no source
`define ROUTE_NONE    0

`endif

/* File: chain_intr_pkg.sv */
package chain_intr_pkg;

  // Input recognition mode; the first entry is the reset mode
  typedef enum logic [1:0] {
    TRIG_FALLING,
    TRIG_RISING,
    TRIG_LOW,
    TRIG_HIGH
  } trig_mode_e;

endpackage : chain_intr_pkg

/* File: recog_if.sv */
`timescale 1ns/1ns
interface recog_if #(
  parameter int N = 20
);
  logic [N-1:0]                        raw_v;
  chain_intr_pkg::trig_mode_e [N-1:0]  mode;
  logic [N-1:0]                        hit;

  modport recognizer (
    input  raw_v,
    input  mode,
    output hit
  );
  modport owner (
    output raw_v,
    output mode,
    input  hit
  );
endinterface : recog_if

/* File: edge_recognizer.sv */
`timescale 1ns/1ns
module edge_recognizer #(
  parameter int N = 20
) (
  // Clock and reset
  input wire logic   clk,
  input wire logic   reset,
  // Inputs, modes and recognized requests
  recog_if.recognizer rif
);

  logic [N-1:0] prev_q;
  logic [N-1:0] prev_d;
  logic         primed_q;
  logic         primed_d;
  logic [N-1:0] edge_mode;

  always_comb
  begin
    prev_d   = rif.raw_v;
    primed_d = 1'b1;
    for (int i = 0; i < N; i++)
    begin
      edge_mode[i] = (rif.mode[i] == chain_intr_pkg::TRIG_FALLING) ||
                     (rif.mode[i] == chain_intr_pkg::TRIG_RISING);
      case (rif.mode[i])
        chain_intr_pkg::TRIG_FALLING: rif.hit[i] = primed_q & prev_q[i] & ~rif.raw_v[i];
        chain_intr_pkg::TRIG_RISING:  rif.hit[i] = primed_q & ~prev_q[i] & rif.raw_v[i];
        chain_intr_pkg::TRIG_LOW:     rif.hit[i] = ~rif.raw_v[i];
        default:                      rif.hit[i] = rif.raw_v[i];
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end
    else
    begin
      prev_q   <= prev_d;
      primed_q <= primed_d;
    end
  end

  property p_edge_needs_change;
    @(posedge clk) disable iff (reset)
      ((rif.hit & edge_mode) != '0) |->
        ((rif.hit & edge_mode & ~(rif.raw_v ^ prev_q)) == '0);
  endproperty
  a_edge_needs_change: assert property (p_edge_needs_change)
    else $error("Edge request without input change");

  property p_no_edge_after_reset;
    @(posedge clk) disable iff (reset)
      !primed_q |-> ((rif.hit & edge_mode) == '0);
  endproperty
  a_no_edge_after_reset: assert property (p_no_edge_after_reset)
    else $error("Edge request before first sample");

endmodule : edge_recognizer

/* File: tod_capture_unit.sv */
`timescale 1ns/1ns
`include "chain_intr_defs.svh"
module tod_capture_unit #(
  parameter int TOD_W      = `TOD_W_DEFAULT,
  parameter bit PPS_RISING = 1'b1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Pulse per second and counter load
  input  wire logic             pps_in,
  input  wire logic             tod_load,
  input  wire logic [TOD_W-1:0] tod_load_value,
  // Counter and capture
  output logic      [TOD_W-1:0] tod_value,
  output logic      [TOD_W-1:0] tod_capture,
  output logic                  capture_valid
);

  logic [TOD_W-1:0] tod_q, tod_d;
  logic [TOD_W-1:0] cap_q, cap_d;
  logic             valid_q, valid_d;
  logic             pps_prev_q, pps_prev_d;
  logic             primed_q, primed_d;
  logic             on_time;

  always_comb
  begin
    on_time    = primed_q & (PPS_RISING ? (pps_in & ~pps_prev_q) : (~pps_in & pps_prev_q));
    tod_d      = tod_load ? tod_load_value : tod_q + TOD_W'(1);
    cap_d      = on_time ? tod_q : cap_q;
    valid_d    = on_time;
    pps_prev_d = pps_in;
    primed_d   = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      tod_q      <= '0;
      cap_q      <= '0;
      valid_q    <= 1'b0;
      pps_prev_q <= 1'b0;
      primed_q   <= 1'b0;
    end
    else
    begin
      tod_q      <= tod_d;
      cap_q      <= cap_d;
      valid_q    <= valid_d;
      pps_prev_q <= pps_prev_d;
      primed_q   <= primed_d;
    end
  end

  assign tod_value     = tod_q;
  assign tod_capture   = cap_q;
  assign capture_valid = valid_q;

  property p_capture_value;
    @(posedge clk) disable iff (reset)
      (on_time && !tod_load) |=> (tod_capture == tod_value - TOD_W'(1)) && capture_valid;
  endproperty
  a_capture_value: assert property (p_capture_value)
    else $error("Captured time does not match counter at on-time edge");

  c_capture: cover property (@(posedge clk) disable iff (reset) capture_valid);

endmodule : tod_capture_unit

/* File: chain_interrupt_control.sv */
// Operation
// - After reset every line is disarmed and disabled.
// - A line delivers only when both armed and enabled, set independently.
// - An armed line sets its request bit on each recognized request.
// - Disarming clears the request and ignores requests while disarmed.
// - Only enabled lines enter priority resolution toward the host interrupt.
// - Disabled armed lines keep requests and deliver once enabled again.
// - Host clears pending after service; next delivery waits for that clear.
// - Edge mode triggers on the leading edge; input must go inactive first.
// - Level mode requests while input is high or low as selected.
// - Interrupt goes to the host; routed sources also go onto the chain.
// - Software request raises only the local interrupt, never the chain line.
// - Routed external input feeds the chain line raw, bypassing local logic.
// - Local and chain interrupts of one source carry distinct vectors.
// - Chain lines start disarmed; signal still propagates along the chain.
// - Any module can be selected as source of each external output.
// - Time-of-day counter is captured on the on-time pulse-per-second edge.
// - Edge mode selects rising or falling edge; falling is the default.
`timescale 1ns/1ns
`include "chain_intr_defs.svh"
module chain_interrupt_control #(
  parameter  int N_ETI   = `N_ETI_DEFAULT,
  parameter  int N_DI    = `N_DI_DEFAULT,
  parameter  int N_RTC   = `N_RTC_DEFAULT,
  parameter  int N_PIG   = `N_PIG_DEFAULT,
  parameter  int N_OUT   = `N_OUT_DEFAULT,
  parameter  int SEL_W   = `SEL_W_DEFAULT,
  parameter  int TOD_W   = `TOD_W_DEFAULT,
  localparam int N_LINE  = N_ETI + N_DI,
  localparam int VEC_W   = $clog2(N_LINE),
  localparam int SRC_N   = N_ETI + N_RTC + N_PIG + N_DI
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       reset,
  // External inputs and software requests
  input  wire logic [N_ETI-1:0]           eti_in,
  input  wire logic [N_ETI-1:0]           sw_request,
  // Other signal sources
  input  wire logic [N_RTC-1:0]           rtc_pulse,
  input  wire logic [N_PIG-1:0]           pig_pulse,
  // Chain lines and external outputs
  input  wire logic [N_DI-1:0]            di_in,
  output logic      [N_DI-1:0]            di_out,
  output logic      [N_OUT-1:0]           ext_out,
  // Line control, one bit per line, external inputs first
  input  wire logic [N_LINE-1:0]          arm_set,
  input  wire logic [N_LINE-1:0]          arm_clr,
  input  wire logic [N_LINE-1:0]          enable_set,
  input  wire logic [N_LINE-1:0]          enable_clr,
  input  wire logic [N_LINE-1:0]          pend_clr,
  input  wire logic [N_LINE-1:0]          mode_wr,
  input  wire chain_intr_pkg::trig_mode_e mode_wdata,
  // Routing configuration
  input  wire logic [N_DI-1:0]            di_route_wr,
  input  wire logic [N_OUT-1:0]           ext_route_wr,
  input  wire logic [SEL_W-1:0]           route_wdata,
  // Host interrupt
  output logic                            irq,
  input  wire logic                       irq_ack,
  output logic      [VEC_W-1:0]           irq_vector,
  // Line status
  output logic      [N_LINE-1:0]          armed,
  output logic      [N_LINE-1:0]          enabled,
  output logic      [N_LINE-1:0]          requested,
  output logic      [N_LINE-1:0]          pending,
  // Time of day
  input  wire logic                       pps_in,
  input  wire logic                       tod_load,
  input  wire logic [TOD_W-1:0]           tod_load_value,
  output logic      [TOD_W-1:0]           tod_value,
  output logic      [TOD_W-1:0]           tod_capture,
  output logic                            tod_capture_valid
);

  if (SRC_N >= (1 << SEL_W) || N_LINE < 2)
  begin : g_param_check
    $error("Route select too narrow for the number of sources");
  end

  // Route select: 0 none, then external inputs, counters, pulse sources, chain lines
  function automatic logic pick(input logic [SEL_W-1:0] sel, input logic [SRC_N-1:0] src);
    logic r;
    r = 1'b0;
    for (int k = 0; k < SRC_N; k++)
    begin
      if (sel == SEL_W'(k + 1))
        r = src[k];
    end
    return r;
  endfunction : pick

  function automatic logic [VEC_W-1:0] first_set(input logic [N_LINE-1:0] v);
    logic [VEC_W-1:0] r;
    r = '0;
    for (int k = N_LINE - 1; k >= 0; k--)
    begin
      if (v[k])
        r = VEC_W'(k);
    end
    return r;
  endfunction : first_set

  logic [N_LINE-1:0]                arm_q, arm_d;
  logic [N_LINE-1:0]                en_q, en_d;
  logic [N_LINE-1:0]                req_q, req_d;
  logic [N_LINE-1:0]                pend_q, pend_d;
  chain_intr_pkg::trig_mode_e [N_LINE-1:0] mode_q, mode_d;
  logic [N_DI-1:0][SEL_W-1:0]       di_route_q, di_route_d;
  logic [N_OUT-1:0][SEL_W-1:0]      ext_route_q, ext_route_d;
  logic [N_DI-1:0]                  di_out_q, di_out_d;
  logic [N_OUT-1:0]                 ext_out_q, ext_out_d;
  logic                             irq_q, irq_d;
  logic [VEC_W-1:0]                 vec_q, vec_d;
  logic [SRC_N-1:0]                 src_all;
  logic [N_LINE-1:0]                ack_mask;
  logic [N_LINE-1:0]                accepted;
  logic [N_LINE-1:0]                deliver;

  recog_if #(.N(N_LINE)) rif ();

  assign rif.raw_v = {di_in, eti_in};
  assign rif.mode  = mode_q;

  edge_recognizer #(.N(N_LINE)) u_recog (
    .clk   (clk),
    .reset (reset),
    .rif   (rif)
  );

  // Line control, requests, pending and priority
  always_comb
  begin
    ack_mask = (irq_ack && irq_q) ? (N_LINE'(1) << vec_q) : '0;
    arm_d    = (arm_q & ~arm_clr) | arm_set;
    en_d     = (en_q & ~enable_clr) | enable_set;
    accepted = rif.hit | {{N_DI{1'b0}}, sw_request};
    req_d    = arm_d & ((req_q & ~ack_mask) | accepted);
    pend_d   = (pend_q & ~pend_clr) | ack_mask;
    deliver  = req_d & arm_d & en_d & ~pend_d;
    irq_d    = |deliver;
    vec_d    = first_set(deliver);
    for (int i = 0; i < N_LINE; i++)
    begin
      mode_d[i] = mode_wr[i] ? mode_wdata : mode_q[i];
    end
  end

  // Routing onto chain lines and external outputs
  always_comb
  begin
    src_all = {di_in, pig_pulse, rtc_pulse, eti_in};
    for (int i = 0; i < N_DI; i++)
    begin
      di_route_d[i] = di_route_wr[i] ? route_wdata : di_route_q[i];
      di_out_d[i]   = di_in[i] | pick(di_route_q[i], src_all);
    end
    for (int i = 0; i < N_OUT; i++)
    begin
      ext_route_d[i] = ext_route_wr[i] ? route_wdata : ext_route_q[i];
      ext_out_d[i]   = pick(ext_route_q[i], src_all);
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      arm_q       <= '0;
      en_q        <= '0;
      req_q       <= '0;
      pend_q      <= '0;
      for (int i = 0; i < N_LINE; i++)
      begin
        mode_q[i] <= chain_intr_pkg::TRIG_FALLING;
      end
      di_route_q  <= '0;
      ext_route_q <= '0;
      di_out_q    <= '0;
      ext_out_q   <= '0;
      irq_q       <= 1'b0;
      vec_q       <= '0;
    end
    else
    begin
      arm_q       <= arm_d;
      en_q        <= en_d;
      req_q       <= req_d;
      pend_q      <= pend_d;
      mode_q      <= mode_d;
      di_route_q  <= di_route_d;
      ext_route_q <= ext_route_d;
      di_out_q    <= di_out_d;
      ext_out_q   <= ext_out_d;
      irq_q       <= irq_d;
      vec_q       <= vec_d;
    end
  end

  tod_capture_unit #(.TOD_W(TOD_W), .PPS_RISING(1'b1)) u_tod (
    .clk            (clk),
    .reset          (reset),
    .pps_in         (pps_in),
    .tod_load       (tod_load),
    .tod_load_value (tod_load_value),
    .tod_value      (tod_value),
    .tod_capture    (tod_capture),
    .capture_valid  (tod_capture_valid)
  );

  assign armed      = arm_q;
  assign enabled    = en_q;
  assign requested  = req_q;
  assign pending    = pend_q;
  assign irq        = irq_q;
  assign irq_vector = vec_q;
  assign di_out     = di_out_q;
  assign ext_out    = ext_out_q;

  // Checks
  logic [N_LINE-1:0] deliver_now;
  logic [N_LINE-1:0] lower_mask;
  logic [N_LINE-1:0] accepted_armed;

  assign deliver_now    = req_q & arm_q & en_q & ~pend_q;
  assign lower_mask     = (N_LINE'(1) << vec_q) - N_LINE'(1);
  assign accepted_armed = accepted & arm_d;

  property p_reset_state;
    @(posedge clk) $fell(reset) |->
      (armed == '0) && (enabled == '0) && (requested == '0) && (pending == '0) && !irq;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("Lines not disarmed and disabled after reset");

  property p_irq_matches;
    @(posedge clk) disable iff (reset) irq == (deliver_now != '0);
  endproperty
  a_irq_matches: assert property (p_irq_matches)
    else $error("Host interrupt does not match deliverable requests");

  property p_no_req_disarmed;
    @(posedge clk) disable iff (reset) (requested & ~armed) == '0;
  endproperty
  a_no_req_disarmed: assert property (p_no_req_disarmed)
    else $error("Request held on a disarmed line");

  property p_request_set;
    @(posedge clk) disable iff (reset)
      (accepted_armed != '0) |=> ((requested & $past(accepted_armed)) == $past(accepted_armed));
  endproperty
  a_request_set: assert property (p_request_set)
    else $error("Accepted request did not set its request bit");

  property p_disabled_hold;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (($past(requested & ~enabled) & armed & ~requested) == '0);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("Disabled armed line lost its request");

  property p_not_pending;
    @(posedge clk) disable iff (reset) irq |-> !pending[irq_vector] && enabled[irq_vector];
  endproperty
  a_not_pending: assert property (p_not_pending)
    else $error("Presented line is pending or disabled");

  property p_lowest_first;
    @(posedge clk) disable iff (reset) irq |-> ((deliver_now & lower_mask) == '0);
  endproperty
  a_lowest_first: assert property (p_lowest_first)
    else $error("Lower deliverable line was skipped");

  property p_chain_propagates;
    @(posedge clk) disable iff (reset) 1'b1 |=> (($past(di_in) & ~di_out) == '0);
  endproperty
  a_chain_propagates: assert property (p_chain_propagates)
    else $error("Chain line did not propagate");

  property p_ack_pends;
    @(posedge clk) disable iff (reset)
      (irq && irq_ack) |=> pending[$past(irq_vector)] ##1 1'b1;
  endproperty
  a_ack_pends: assert property (p_ack_pends)
    else $error("Acknowledged line did not become pending");

  property p_disarm_clears;
    @(posedge clk) disable iff (reset)
      ((arm_clr & ~arm_set) != '0) |=> ((requested & $past(arm_clr & ~arm_set)) == '0);
  endproperty
  a_disarm_clears: assert property (p_disarm_clears)
    else $error("Disarmed line kept its request");

  property p_pend_clear;
    @(posedge clk) disable iff (reset)
      ((pend_clr != '0) && !irq_ack) |=> ((pending & $past(pend_clr)) == '0);
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("Pending bit not cleared by the host");

  c_deliver: cover property (@(posedge clk) disable iff (reset) irq && irq_ack);
  c_chain_out: cover property (@(posedge clk) disable iff (reset) di_out != '0);
  c_ext_out: cover property (@(posedge clk) disable iff (reset) ext_out != '0);
  c_held: cover property (@(posedge clk) disable iff (reset) (requested & pending) != '0);

endmodule : chain_interrupt_control

/* File: host_model.sv */
`timescale 1ns/1ns
module host_model #(
  parameter int NL  = 20,
  parameter int VW  = 5,
  parameter int DLY = 2
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Host interrupt
  input  wire logic          irq,
  input  wire logic [VW-1:0] irq_vector,
  output logic               irq_ack,
  output logic [NL-1:0]      pend_clr,
  // Service control and log
  input  wire logic          service_en,
  output logic [VW-1:0]      last_vec,
  output logic [7:0]         ack_count
);
  logic [NL-1:0] owed;
  int            wait_cnt;

  // Takes the presented line after DLY cycles, clears pending once service is allowed
  always @(posedge clk)
  begin
    irq_ack  <= 1'b0;
    pend_clr <= '0;
    if (reset)
    begin
      owed      <= '0;
      wait_cnt  <= 0;
      last_vec  <= '0;
      ack_count <= 8'h00;
    end
    else
    begin
      if (service_en && owed != '0)
      begin
        pend_clr <= owed;
        owed     <= '0;
      end
      if (irq && !irq_ack && wait_cnt == DLY)
      begin
        irq_ack          <= 1'b1;
        last_vec         <= irq_vector;
        ack_count        <= ack_count + 8'h01;
        owed[irq_vector] <= 1'b1;
        wait_cnt         <= 0;
      end
      else if (irq && !irq_ack)
        wait_cnt <= wait_cnt + 1;
      else
        wait_cnt <= 0;
    end
  end
endmodule : host_model

/* File: chain_interrupt_control_tb_top.sv */
`timescale 1ns/1ns
`include "chain_intr_defs.svh"
module chain_interrupt_control_tb_top;
  localparam int HOLD = `MIN_HOLD_CYC;
  logic        clk = 1'b0, reset = 1'b1, pps = 1'b0, tod_ld = 1'b0, service_en = 1'b0;
  logic [11:0] ext_in = 12'hFFF, sw_req = 12'h000;
  logic [7:0]  rtc_src = 8'h00, chain_in = 8'hFF, chain_wr = 8'h00, chain_out, ack_count;
  logic [3:0]  pulse_src = 4'h0, out_wr = 4'h0, ext_out;
  logic [5:0]  sel = 6'h00;
  logic [19:0] arm_s = '0, arm_c = '0, en_s = '0, en_c = '0, mode_w = '0, pend_c;
  logic [19:0] armed, enabled, requested, pending;
  logic [4:0]  vec, last_vec;
  logic        irq, irq_ack, cap_valid;
  logic [31:0] tod_lv = 32'h0000_0100, tod_now, tod_cap, v;
  chain_intr_pkg::trig_mode_e mode_val = chain_intr_pkg::TRIG_FALLING;
  int          miscompares = 0, check_count = 0, i;
  int          sels[4] = '{12, 20, 24, 32};

  always #4 clk = ~clk;

  chain_interrupt_control i_dut (
    .clk(clk), .reset(reset), .eti_in(ext_in), .sw_request(sw_req),
    .rtc_pulse(rtc_src), .pig_pulse(pulse_src), .di_in(chain_in), .di_out(chain_out),
    .ext_out(ext_out), .arm_set(arm_s), .arm_clr(arm_c), .enable_set(en_s),
    .enable_clr(en_c), .pend_clr(pend_c), .mode_wr(mode_w), .mode_wdata(mode_val),
    .di_route_wr(chain_wr), .ext_route_wr(out_wr), .route_wdata(sel), .irq(irq),
    .irq_ack(irq_ack), .irq_vector(vec), .armed(armed), .enabled(enabled),
    .requested(requested), .pending(pending), .pps_in(pps), .tod_load(tod_ld),
    .tod_load_value(tod_lv), .tod_value(tod_now), .tod_capture(tod_cap),
    .tod_capture_valid(cap_valid));

  host_model #(.NL(20), .VW(5), .DLY(2)) i_host (
    .clk(clk), .reset(reset), .irq(irq), .irq_vector(vec), .irq_ack(irq_ack),
    .pend_clr(pend_c), .service_en(service_en), .last_vec(last_vec),
    .ack_count(ack_count));

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  // Kind 0 arm, 1 disarm, 2 enable, 3 disable, 4 mode write
  task automatic ctl(input int k, input logic [19:0] m);
    @(posedge clk);
    case (k)
      0: arm_s <= m;
      1: arm_c <= m;
      2: en_s <= m;
      3: en_c <= m;
      default: mode_w <= m;
    endcase
    @(posedge clk);
    arm_s  <= '0;
    arm_c  <= '0;
    en_s   <= '0;
    en_c   <= '0;
    mode_w <= '0;
    cyc(1);
  endtask : ctl

  // Sources packed chain, pulse, timer, external from the top down
  task automatic drive(input logic [31:0] s);
    @(posedge clk);
    {chain_in, pulse_src, rtc_src, ext_in} <= s;
    cyc(HOLD);
  endtask : drive

  task automatic route(input bit to_out, input int idx, input int s);
    @(posedge clk);
    sel <= s[5:0];
    if (to_out)
      out_wr[idx] <= 1'b1;
    else
      chain_wr[idx] <= 1'b1;
    @(posedge clk);
    out_wr   <= '0;
    chain_wr <= '0;
    cyc(1);
  endtask : route

  task automatic wait_ack(input logic [7:0] n);
    for (i = 0; i < 50 && ack_count !== n; i++)
      cyc(1);
    check_count++;
    if (ack_count !== n)
    begin
      miscompares++;
      $display("MISMATCH ack count expected %0h seen %0h", n, ack_count);
      results();
    end
  endtask : wait_ack

  initial
  begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    cyc(2);
    chk("armed", 0, armed);
    chk("enabled", 0, enabled);
    chk("requested", 0, requested | pending | irq);
    // Armed but disabled line holds its request
    ctl(0, 20'h00004);
    chk("armed", 20'h4, armed);
    drive(32'hFF00_0FFB);
    chk("requested", 20'h4, requested);
    chk("irq disabled", 0, irq);
    ctl(2, 20'h00004);
    wait_ack(8'h01);
    chk("vector", 2, last_vec);
    cyc(2);
    chk("pending", 20'h4, pending);
    chk("requested", 0, requested);
    drive(32'hFF00_0FFF);
    drive(32'hFF00_0FFB);
    chk("held request", 20'h4, requested);
    chk("irq pending", 0, irq);
    @(posedge clk) service_en <= 1'b1;
    wait_ack(8'h02);
    cyc(20);
    chk("pending", 0, pending);
    chk("ack count", 2, ack_count);
    ctl(1, 20'h00004);
    ctl(3, 20'h00004);
    // Disarm drops the request and ignores new ones
    ctl(0, 20'h00008);
    drive(32'hFF00_0FF3);
    chk("requested", 20'h8, requested);
    ctl(1, 20'h00008);
    chk("requested", 0, requested);
    drive(32'hFF00_0FFB);
    drive(32'hFF00_0FF3);
    chk("requested", 0, requested);
    drive(32'hFF00_0FFF);
    // Every recognition mode on line 6
    for (int m = 0; m < 4; m++)
    begin
      ctl(1, 20'h00040);
      v = 32'hFF00_0FFF;
      v[6] = ~m[0];
      drive(v);
      @(posedge clk) mode_val <= chain_intr_pkg::trig_mode_e'(m);
      ctl(4, 20'h00040);
      ctl(0, 20'h00040);
      cyc(HOLD);
      chk("idle level", 0, requested);
      v[6] = m[0];
      drive(v);
      chk("active", 20'h40, requested);
    end
    ctl(1, 20'h00040);
    drive(32'hFF00_0FFF);
    // Lowest line first, local and chain lines with their own vectors
    ctl(0, 20'h01001);
    ctl(2, 20'h01001);
    @(posedge clk) {chain_in, ext_in} <= {8'hFE, 12'hFFE};
    wait_ack(8'h03);
    chk("first vector", 0, last_vec);
    wait_ack(8'h04);
    chk("second vector", 12, last_vec);
    ctl(1, 20'h01001);
    ctl(3, 20'h01001);
    // Routed input bypasses local logic, software request stays local
    route(0, 0, 6);
    drive(32'h0000_0FFF);
    chk("chain out", 8'h01, chain_out);
    chk("requested", 0, requested);
    drive(32'h0000_0FDF);
    chk("chain out", 8'h00, chain_out);
    ctl(0, 20'h00020);
    @(posedge clk) sw_req <= 12'h020;
    @(posedge clk) sw_req <= 12'h000;
    cyc(2);
    chk("sw requested", 20'h20, requested);
    chk("chain out", 8'h00, chain_out);
    ctl(1, 20'h00020);
    route(0, 0, 0);
    // Last source of each kind onto an external output, routed one at a time
    for (int j = 0; j < 4; j++)
    begin
      route(1, 1, sels[j]);
      drive(32'h1 << (sels[j] - 1));
      chk("ext out on", 4'h2, ext_out);
      drive(~(32'h1 << (sels[j] - 1)));
      chk("ext out off", 4'h0, ext_out);
    end
    // Counter capture on the on-time edge
    @(posedge clk) tod_ld <= 1'b1;
    @(posedge clk) tod_ld <= 1'b0;
    repeat (5) @(posedge clk);
    pps <= 1'b1;
    cyc(1);
    for (i = 0; i < 10 && cap_valid !== 1'b1; i++)
      cyc(1);
    chk("capture valid", 1, cap_valid);
    chk("capture", 32'h0000_0105, tod_cap);
    cyc(1);
    chk("capture pulse", 0, cap_valid);
    chk("tod value", 32'h0000_0107, tod_now);
    @(posedge clk) pps <= 1'b0;
    results();
  end
endmodule : chain_interrupt_control_tb_top
